// ---- hdl/can_global_status_defines.vh ----
`ifndef CAN_GLOBAL_STATUS_DEFINES_VH
`define CAN_GLOBAL_STATUS_DEFINES_VH

// register word addresses on the software port
`define ADDR_STATUS_CONTROL 20'hF_FC10
`define ADDR_IRQ_STATUS     20'hF_FC14
`define ADDR_IRQ_MASK       20'hF_FC18

// read layout
`define BIT_ERR_FLAG        7
`define BIT_SHUTDOWN        3
`define BIT_TSTAMP          2
`define BIT_GLOBAL_OP       0
`define BIT_CONST_ONE       8

// write layout: set and clear positions
`define SET_SHUTDOWN        11
`define SET_TSTAMP          10
`define SET_GLOBAL_OP       8
`define CLR_ERR_FLAG        7
`define CLR_SHUTDOWN        3
`define CLR_TSTAMP          2
`define CLR_GLOBAL_OP       0

// reset state of the field bits
`define FIELD_RESET         1'b0
`define STATUS_RESET_VALUE  16'h0100

// interrupt status bits
`define IRQ_WIDTH           3
`define IRQ_BIT_ERR         0
`define IRQ_BIT_GOM_ON      1
`define IRQ_BIT_GOM_OFF     2

`endif

// ---- hdl/set_clear_field.v ----
`timescale 1ns/1ps
`default_nettype none
`include "can_global_status_defines.vh"

// one status bit driven by a set/clear pair in a single write
module set_clear_field (
    input  wire ref_clk,
    input  wire rstn,
    input  wire wr_en,
    input  wire set_req,
    input  wire clr_req,
    input  wire clr_allowed,
    output reg  value_q
);

    reg value_d;

    // only 1/0 pairs, or 0/1 pairs while clr_allowed is high, act; anything else keeps the bit
    always @* begin
        value_d = value_q;
        if (wr_en && set_req && !clr_req) begin
            value_d = 1'b1;
        end else if (wr_en && clr_req && !set_req && clr_allowed) begin
            value_d = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            value_q <= `FIELD_RESET;
        end else begin
            value_q <= value_d;
        end
    end

endmodule // set_clear_field

`default_nettype wire

// ---- hdl/can_global_status.v ----
`timescale 1ns/1ps
`default_nettype none
`include "can_global_status_defines.vh"

// Notes on behaviour
// - register is 16 bits wide, accessed only as whole 16-bit words.
// - set at bits 11,10,8; clears at 7,3,2,0 for error and fields.
// - access to an invalid controller address sets the error flag.
// - access forbidden in the current state sets the error flag.
// - clearing global enable before module initialise request raises error flag.
// - shutdown bit 1 allowed, 0 forbidden; timestamp bit 1 running, 0 stopped.
// - set=1/clear=0 sets, clear=1/set=0 clears, else unchanged; error clear.
// - global disabled holds modules in reset; enabled blocks temporary buffer.
// - global enable clears only when every module is in initial status.
module can_global_status #(
    parameter MODULES = 1
) (
    input  wire                  ref_clk,
    input  wire                  rstn,
    input  wire [19:0]           addr,
    input  wire [15:0]           wdata,
    input  wire                  wr_stb,
    input  wire                  rd_stb,
    output reg  [15:0]           rdata,
    input  wire [MODULES-1:0]    module_init_req,
    input  wire [MODULES-1:0]    module_in_init,
    input  wire                  invalid_access,
    input  wire                  module_reg_access,
    input  wire                  temp_buf_access,
    output reg                   modules_reset_q,
    output reg                   module_regs_open_q,
    output reg                   temp_buf_open_q,
    output reg                   shutdown_allowed_q,
    output reg                   timestamp_run_q,
    output reg                   irq_q
);

    wire                  global_operation_enable;
    wire                  shutdown_enable;
    wire                  timestamp_run;
    reg                   access_error_flag_q;
    reg                   access_error_flag_d;
    reg [`IRQ_WIDTH-1:0]  irq_status_q;
    reg [`IRQ_WIDTH-1:0]  irq_status_d;
    reg [`IRQ_WIDTH-1:0]  irq_mask_q;
    reg [`IRQ_WIDTH-1:0]  irq_events;
    reg                   gom_q_prev;
    reg [15:0]            rdata_d;

    // full 20-bit match; a partial decode would alias the word elsewhere
    function addr_hit;
        input [19:0] bus_addr;
        input [19:0] target;
        begin
            addr_hit = (bus_addr == target);
        end
    endfunction

    // status word as software reads it; unnamed bits zero, bit 8 fixed at one
    function [15:0] status_word;
        input err_flag;
        input sd_en;
        input ts_run;
        input gom_en;
        begin
            status_word                 = 16'h0000;
            status_word[`BIT_CONST_ONE] = 1'b1;
            status_word[`BIT_ERR_FLAG]  = err_flag;
            status_word[`BIT_SHUTDOWN]  = sd_en;
            status_word[`BIT_TSTAMP]    = ts_run;
            status_word[`BIT_GLOBAL_OP] = gom_en;
        end
    endfunction

    // write strobes per register; whole 16-bit words only, never byte lanes
    wire wr_main       = wr_stb && addr_hit(addr, `ADDR_STATUS_CONTROL);
    wire wr_irq_status = wr_stb && addr_hit(addr, `ADDR_IRQ_STATUS);
    wire wr_irq_mask   = wr_stb && addr_hit(addr, `ADDR_IRQ_MASK);

    // module handshake summaries
    wire all_init             = &module_in_init;
    wire any_init_req_missing = ~&module_init_req;

    // a global enable clear request, whether or not it will be honoured
    wire gom_clr_req = wr_main && wdata[`CLR_GLOBAL_OP] && !wdata[`SET_GLOBAL_OP];

    // global enable: clear refused while any module is still running
    set_clear_field u_gom (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .wr_en       (wr_main),
        .set_req     (wdata[`SET_GLOBAL_OP]),
        .clr_req     (wdata[`CLR_GLOBAL_OP]),
        .clr_allowed (all_init),
        .value_q     (global_operation_enable)
    );

    // shutdown enable: not gated here; software keeps it apart from global enable
    set_clear_field u_shutdown (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .wr_en       (wr_main),
        .set_req     (wdata[`SET_SHUTDOWN]),
        .clr_req     (wdata[`CLR_SHUTDOWN]),
        .clr_allowed (1'b1),
        .value_q     (shutdown_enable)
    );

    // timestamp run bit; the counter itself lives outside this block
    set_clear_field u_tstamp (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .wr_en       (wr_main),
        .set_req     (wdata[`SET_TSTAMP]),
        .clr_req     (wdata[`CLR_TSTAMP]),
        .clr_allowed (1'b1),
        .value_q     (timestamp_run)
    );

    // error sources; the order error is flagged even when the clear is refused
    wire err_invalid  = invalid_access;
    wire err_forbid   = (module_reg_access && !global_operation_enable)
                      || (temp_buf_access && global_operation_enable);
    wire err_order    = gom_clr_req && global_operation_enable
                      && any_init_req_missing;
    wire err_any      = err_invalid || err_forbid || err_order;

    // error flag; a new error beats a clear in the same cycle
    always @* begin
        access_error_flag_d = access_error_flag_q;
        if (wr_main && wdata[`CLR_ERR_FLAG]) begin
            access_error_flag_d = 1'b0;
        end
        if (err_any) begin
            access_error_flag_d = 1'b1;
        end
    end

    // interrupt events: error, global enable rising and falling
    always @* begin
        irq_events = {`IRQ_WIDTH{1'b0}};
        irq_events[`IRQ_BIT_ERR]     = err_any;
        irq_events[`IRQ_BIT_GOM_ON]  = global_operation_enable && !gom_q_prev;
        irq_events[`IRQ_BIT_GOM_OFF] = !global_operation_enable && gom_q_prev;
        irq_status_d = irq_status_q;
        if (wr_irq_status) begin
            irq_status_d = irq_status_q & ~wdata[`IRQ_WIDTH-1:0];
        end
        irq_status_d = irq_status_d | irq_events; // set wins over clear
    end

    // read mux; the bus reads zero outside a read slot
    always @* begin
        rdata_d = 16'h0000;
        if (rd_stb) begin
            case (addr)
                `ADDR_STATUS_CONTROL: begin
                    rdata_d = status_word(access_error_flag_q, shutdown_enable,
                                          timestamp_run, global_operation_enable);
                end
                `ADDR_IRQ_STATUS: begin
                    rdata_d[`IRQ_WIDTH-1:0] = irq_status_q;
                end
                `ADDR_IRQ_MASK: begin
                    rdata_d[`IRQ_WIDTH-1:0] = irq_mask_q;
                end
                default: begin
                    rdata_d = 16'h0000;
                end
            endcase
        end
    end

    // mask register; written whole, unlike the status word
    always @(posedge ref_clk) begin
        if (!rstn) begin
            irq_mask_q <= {`IRQ_WIDTH{1'b0}};
        end else if (wr_irq_mask) begin
            irq_mask_q <= wdata[`IRQ_WIDTH-1:0];
        end
    end

    // error flag, interrupt status and the edge tracker for global enable
    always @(posedge ref_clk) begin
        if (!rstn) begin
            access_error_flag_q <= `FIELD_RESET;
            irq_status_q        <= {`IRQ_WIDTH{1'b0}};
            gom_q_prev          <= 1'b0;  // equals field reset, so no false edge
        end else begin
            access_error_flag_q <= access_error_flag_d;
            irq_status_q        <= irq_status_d;
            gom_q_prev          <= global_operation_enable;
        end
    end

    // registered outputs; mirrors follow the fields one cycle later
    always @(posedge ref_clk) begin
        if (!rstn) begin
            rdata               <= 16'h0000;
            modules_reset_q     <= 1'b1;
            module_regs_open_q  <= 1'b0;
            temp_buf_open_q     <= 1'b1;
            shutdown_allowed_q  <= 1'b0;
            timestamp_run_q     <= 1'b0;
            irq_q               <= 1'b0;
        end else begin
            rdata               <= rdata_d;
            modules_reset_q     <= !global_operation_enable;
            module_regs_open_q  <= global_operation_enable;
            temp_buf_open_q     <= !global_operation_enable;
            shutdown_allowed_q  <= shutdown_enable;
            timestamp_run_q     <= timestamp_run;
            irq_q               <= |(irq_status_d & irq_mask_q);
        end
    end

endmodule // can_global_status

`default_nettype wire

// ---- tb/can_global_status_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "can_global_status_defines.vh"
// watches the software port and the mirror outputs of the status register
module can_global_status_asserts #(parameter MODULES = 1) (
    input wire logic               ref_clk,
    input wire logic               rstn,
    input wire logic [19:0]        addr,
    input wire logic [15:0]        wdata,
    input wire logic               wr_stb,
    input wire logic               rd_stb,
    input wire logic [15:0]        rdata,
    input wire logic [MODULES-1:0] module_init_req,
    input wire logic [MODULES-1:0] module_in_init,
    input wire logic               invalid_access,
    input wire logic               module_reg_access,
    input wire logic               temp_buf_access,
    input wire logic               modules_reset_q,
    input wire logic               module_regs_open_q,
    input wire logic               temp_buf_open_q,
    input wire logic               shutdown_allowed_q,
    input wire logic               timestamp_run_q,
    input wire logic               irq_q
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rstn);
// status word strobes
sequence s_wr; wr_stb && addr == `ADDR_STATUS_CONTROL; endsequence
sequence s_rd; rd_stb && addr == `ADDR_STATUS_CONTROL; endsequence
property p_idle; !rd_stb |=> rdata == 16'h0000; endproperty
property p_fixed; s_rd |=> rdata[8] && rdata[15:9] == 7'h00 && rdata[6:4] == 3'h0 && !rdata[1];
endproperty
property p_mirror; modules_reset_q != module_regs_open_q && temp_buf_open_q == modules_reset_q;
endproperty
property p_gom_set; s_wr ##0 (wdata[8] && !wdata[0]) |=> ##1 !modules_reset_q; endproperty
// mirror lags a cycle, so a quiet cycle before makes the sampled mirror current
property p_gom_keep;
    s_wr ##0 (wdata[0] && !wdata[8] && !(&module_in_init) && !modules_reset_q && !$past(wr_stb))
    |=> ##1 !modules_reset_q;
endproperty
property p_gom_clr; s_wr ##0 (wdata[0] && !wdata[8] && &module_in_init) |=> ##1 modules_reset_q;
endproperty
property p_sd; s_wr ##0 (wdata[11] && !wdata[3]) |=> ##1 shutdown_allowed_q; endproperty
property p_ts_hold;
    s_wr ##0 (wdata[10] == wdata[2]) |=> ##1 timestamp_run_q == $past(timestamp_run_q);
endproperty
// no error-clear write may fall between the event and the read
property p_err;
    invalid_access ##1 !(wr_stb && addr == `ADDR_STATUS_CONTROL && wdata[7]) ##1 s_rd
    |=> rdata[7];
endproperty
a_idle: assert property (p_idle) else $error("read data outside read slot");
a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
a_mirror: assert property (p_mirror) else $error("access gates disagree");
a_gom_set: assert property (p_gom_set) else $error("global enable not set");
a_gom_keep: assert property (p_gom_keep) else $error("refused clear took effect");
a_gom_clr: assert property (p_gom_clr) else $error("global enable not cleared");
a_sd: assert property (p_sd) else $error("shutdown enable not set");
a_ts_hold: assert property (p_ts_hold) else $error("timestamp bit moved");
a_err: assert property (p_err) else $error("error flag missing");
endmodule // can_global_status_asserts
bind can_global_status can_global_status_asserts #(.MODULES(MODULES)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .module_init_req(module_init_req),
    .module_in_init(module_in_init), .invalid_access(invalid_access),
    .module_reg_access(module_reg_access), .temp_buf_access(temp_buf_access),
    .modules_reset_q(modules_reset_q), .module_regs_open_q(module_regs_open_q),
    .temp_buf_open_q(temp_buf_open_q), .shutdown_allowed_q(shutdown_allowed_q),
    .timestamp_run_q(timestamp_run_q), .irq_q(irq_q));
`default_nettype wire

// ---- tb/can_global_status_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "can_global_status_defines.vh"
module can_global_status_bench;
logic ref_clk, rstn, wr_stb, rd_stb, inv, mra, tba;
logic [19:0] addr;
logic [15:0] wdata, rdv, ex, w;
logic [1:0] ireq, iin;
wire [15:0] rdata;
wire mrst, mopen, topen, sd, ts, irq;
integer fails = 0, total_checks = 0, seed = 40, i;
can_global_status #(.MODULES(2)) uut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .module_init_req(ireq),
    .module_in_init(iin), .invalid_access(inv), .module_reg_access(mra),
    .temp_buf_access(tba), .modules_reset_q(mrst), .module_regs_open_q(mopen),
    .temp_buf_open_q(topen), .shutdown_allowed_q(sd), .timestamp_run_q(ts), .irq_q(irq));
initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
end
// expected status word after one set/clear write
function automatic [15:0] nxt(input [15:0] c, input [15:0] v);
    nxt = c;
    for (int k = 0; k < 3; k++) begin
        if (v[k+8] && !v[k]) nxt[k] = 1'b1;
        if (v[k] && !v[k+8]) nxt[k] = 1'b0;
    end
    nxt[1] = 1'b0;
    if (v[11] && !v[3]) nxt[3] = 1'b1;
    if (v[3] && !v[11]) nxt[3] = 1'b0;
    if (v[7]) nxt[7] = 1'b0;
endfunction
task automatic chk(input [15:0] g, input [15:0] e);
    total_checks++;
    if (g !== e) begin
        fails++;
        $display("FAIL %0t got %h want %h", $time, g, e);
    end
endtask
task automatic wr(input [19:0] a, input [15:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
endtask
task automatic rd(input [19:0] a);
    @(posedge ref_clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 rdv = rdata;
endtask
// one-cycle event pulse on a side input
task automatic pulse(input int s);
    @(posedge ref_clk);
    inv <= (s == 0); mra <= (s == 1); tba <= (s == 2);
    @(posedge ref_clk);
    {inv, mra, tba} <= 3'b000;
endtask
task automatic give_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin
    #300000;
    fails++;
    give_verdict;
end
initial begin
    {rstn, wr_stb, rd_stb, inv, mra, tba} = 0;
    addr = 0; wdata = 0; ireq = 2'b11; iin = 2'b11;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`ADDR_STATUS_CONTROL); chk(rdv, 16'h0100);
    chk({15'h0, irq}, 16'h0000);
    rd(20'h0_0000); chk(rdv, 16'h0000);
    ex = 16'h0100;
    for (i = 0; i < 40; i++) begin
        // set/clear and error-clear bits only, and global enable never shares a write with shutdown
        w = (i == 0) ? 16'h0C00 : (i == 1) ? 16'h0100 :
            16'($random(seed)) & ((i % 2) ? 16'h0C8C : 16'h0581);
        wr(`ADDR_STATUS_CONTROL, w); ex = nxt(ex, w);
        rd(`ADDR_STATUS_CONTROL); chk(rdv, ex);
        chk({14'h0, sd, ts}, {14'h0, ex[3], ex[2]});
    end
    $display("test set_clear done");
    wr(`ADDR_STATUS_CONTROL, 16'h0100); ireq <= 2'b01; iin <= 2'b10;
    wr(`ADDR_STATUS_CONTROL, 16'h0001); rd(`ADDR_STATUS_CONTROL);
    chk(rdv & 16'h0081, 16'h0081);
    chk({15'h0, topen}, 16'h0000);
    wr(`ADDR_STATUS_CONTROL, 16'h0080); rd(`ADDR_STATUS_CONTROL);
    chk(rdv & 16'h0080, 16'h0000);
    pulse(2); rd(`ADDR_STATUS_CONTROL); chk(rdv & 16'h0080, 16'h0080);
    ireq <= 2'b11; iin <= 2'b11;
    wr(`ADDR_STATUS_CONTROL, 16'h0081); pulse(1); rd(`ADDR_STATUS_CONTROL);
    chk(rdv & 16'h0081, 16'h0080);
    $display("test access_error done");
    wr(`ADDR_STATUS_CONTROL, 16'h0080); wr(`ADDR_IRQ_STATUS, 16'h0007);
    wr(`ADDR_IRQ_MASK, 16'h0000); pulse(0); rd(`ADDR_STATUS_CONTROL);
    chk(rdv & 16'h0080, 16'h0080);
    chk({15'h0, irq}, 16'h0000);
    wr(`ADDR_IRQ_MASK, 16'h0001); repeat (2) @(posedge ref_clk);
    chk({15'h0, irq}, 16'h0001);
    wr(`ADDR_IRQ_STATUS, 16'h0001); repeat (2) @(posedge ref_clk);
    chk({15'h0, irq}, 16'h0000);
    $display("test interrupt done");
    give_verdict;
end
endmodule // can_global_status_bench
`default_nettype wire
